// file: hdl/frame_builder.sv
// composes one output frame, left aligned, and its length in bits
// assumes all inputs belong to the clk_in domain; purely combinational
`timescale 1ns/10ps
`include "frame_ctl_regs.svh"

module frame_builder (
    input wire logic [13:0] result_in,
    input wire logic [2:0] value_select_in,
    input wire logic node_id_append_in,
    input wire logic [1:0] supply_alarm_append_in,
    input wire logic [1:0] input_alarm_append_in,
    input wire logic span_setting_append_in,
    input wire logic parity_append_enable_in,
    input wire logic [3:0] node_id_in,
    input wire logic supply_alarm_hi_in,
    input wire logic supply_alarm_lo_in,
    input wire logic input_alarm_hi_in,
    input wire logic input_alarm_lo_in,
    input wire logic [3:0] span_select_in,
    output logic [27:0] frame_out,
    output logic [4:0] len_out
);

    logic [13:0] value;
    logic [27:0] acc;
    logic [4:0] len;
    logic frame_par;
    logic result_par;

    always_comb begin
        if (!value_select_in[`BIT_VALUE_SEL_HI]) begin
            value = result_in;
        end else begin
            case (value_select_in)
                frame_ctl_pkg::VALUE_ZEROS: value = `PATTERN_ZEROS;
                frame_ctl_pkg::VALUE_ONES: value = `PATTERN_ONES;
                frame_ctl_pkg::VALUE_ALT1: value = `PATTERN_ALT1;
                frame_ctl_pkg::VALUE_ALT2: value = `PATTERN_ALT2;
                default: value = result_in;
            endcase
        end
        acc = {14'h0000, value};
        len = 5'd14;
        result_par = ^value;
        frame_par = ^value;
        // fixed order after the result: id, supply, input, span, parity
        if (node_id_append_in) begin
            acc = {acc[23:0], node_id_in};
            len = len + 5'd4;
            frame_par = frame_par ^ (^node_id_in);
        end
        if (supply_alarm_append_in[0]) begin
            acc = {acc[26:0], supply_alarm_hi_in};
            len = len + 5'd1;
            frame_par = frame_par ^ supply_alarm_hi_in;
        end
        if (supply_alarm_append_in[1]) begin
            acc = {acc[26:0], supply_alarm_lo_in};
            len = len + 5'd1;
            frame_par = frame_par ^ supply_alarm_lo_in;
        end
        if (input_alarm_append_in[0]) begin
            acc = {acc[26:0], input_alarm_hi_in};
            len = len + 5'd1;
            frame_par = frame_par ^ input_alarm_hi_in;
        end
        if (input_alarm_append_in[1]) begin
            acc = {acc[26:0], input_alarm_lo_in};
            len = len + 5'd1;
            frame_par = frame_par ^ input_alarm_lo_in;
        end
        if (span_setting_append_in) begin
            acc = {acc[23:0], span_select_in};
            len = len + 5'd4;
            frame_par = frame_par ^ (^span_select_in);
        end
        if (parity_append_enable_in) begin
            // result parity stays out of the frame parity sum
            acc = {acc[25:0], result_par, frame_par};
            len = len + 5'd2;
        end
        frame_out = acc << (5'd28 - len);
        len_out = len;
    end

endmodule : frame_builder

// file: hdl/frame_ctl_pkg.sv
// types shared by the output frame control block
// assumes nothing of its surroundings
package frame_ctl_pkg;

    typedef enum logic [1:0] {
        SHIFT_IDLE,
        SHIFT_RUN,
        SHIFT_DONE
    } shift_state_t;

    typedef enum logic [2:0] {
        VALUE_ZEROS = 3'h4,
        VALUE_ONES = 3'h5,
        VALUE_ALT1 = 3'h6,
        VALUE_ALT2 = 3'h7
    } value_pattern_t;

endpackage : frame_ctl_pkg

// file: hdl/frame_ctl_regs.svh
// register offsets, field positions, reset values and sizes of the
// output frame control block; included by bare name where needed
`ifndef FRAME_CTL_REGS_SVH
`define FRAME_CTL_REGS_SVH

`define OFS_OUTPUT_FRAME_CONTROL 8'h10
`define OFS_SPAN_AND_REF_SELECT 8'h14

`define CTL_WR_MASK 16'h7D0F
`define CTL_KEEP_MASK 16'h0008
`define CTL_RESET 16'h0000
`define SPAN_WR_MASK 8'h4F
`define SPAN_KEEP_MASK 8'h0F
`define SPAN_RESET 8'h00

`define BIT_NODE_ID_APPEND 14
`define BIT_SUPPLY_ALARM_HI 13
`define BIT_SUPPLY_ALARM_LO 12
`define BIT_INPUT_ALARM_HI 11
`define BIT_INPUT_ALARM_LO 10
`define BIT_SPAN_SETTING_APPEND 8
`define BIT_PARITY_APPEND_ENABLE 3
`define BIT_VALUE_SEL_HI 2
`define BIT_VREF_OFF 6

`define RESULT_W 14
`define FRAME_MAX 28
`define LEN_W 5

`define PATTERN_ZEROS 14'h0000
`define PATTERN_ONES 14'h3FFF
`define PATTERN_ALT1 14'h1555
`define PATTERN_ALT2 14'h0CCC

`endif

// file: hdl/frame_ctl_top.sv
// output frame control: apb register file and serial frame shifter
// assumes apb master on clk_in; sclk and frame select come from pins
//
// Notes on behaviour
// - bit 14 set inserts the 4-bit node identifier into the frame
// - bits 13-12 choose which supply alarm flags are appended
// - bits 11-10 choose which input alarm flags are appended
// - bit 8 set appends the 4-bit span setting
// - bit 3 set appends two parity bits, frame grows by two
// - first parity bit: even parity over the result bits only
// - second parity bit: even parity over whole frame minus result parity
// - value select 0xx passes result, 100 zeros, 101 ones
// - value select 110 alternates single bits, 111 alternates pairs
// - reserved control bits ignore writes and read zero
// - control word at 10h-13h, written byte by byte, low byte lowest
// - word at 14h: reference off at bit 6, span select bits 3-0
// - parity enable and span select survive application reset only
// - span codes 0000-0100 bipolar, 1000-1011 unipolar
// - reference off bit 0 enables the on-chip reference
`timescale 1ns/10ps
`include "frame_ctl_regs.svh"

module frame_ctl_top (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic app_reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [13:0] conv_data_in,
    input wire logic conv_valid_in,
    input wire logic [3:0] node_id_in,
    input wire logic supply_alarm_hi_in,
    input wire logic supply_alarm_lo_in,
    input wire logic input_alarm_hi_in,
    input wire logic input_alarm_lo_in,
    input wire logic sclk_in,
    input wire logic frame_sel_n_in,
    output logic serial_out_lanes_out,
    output logic onchip_vref_off_out,
    output logic [3:0] span_select_out,
    output logic [4:0] frame_len_out
);

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb,
        input logic [31:0] wmask
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        merge_bytes = res & wmask;
    endfunction : merge_bytes

    // register file
    logic [15:0] ctl_q, ctl_d;
    logic [7:0] span_q, span_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [13:0] result_q, result_d;
    logic hit_ctl, hit_span, wr_commit;
    logic [31:0] rd_word;
    logic [31:0] ctl_merged, span_merged;

    assign hit_ctl = (paddr_in == `OFS_OUTPUT_FRAME_CONTROL);
    assign hit_span = (paddr_in == `OFS_SPAN_AND_REF_SELECT);
    assign wr_commit = psel_in && penable_in && pready_q && pwrite_in;
    assign ctl_merged = merge_bytes({16'h0000, ctl_q}, pwdata_in, pstrb_in,
                                    {16'h0000, `CTL_WR_MASK});
    assign span_merged = merge_bytes({24'h000000, span_q}, pwdata_in,
                                     pstrb_in, {24'h000000, `SPAN_WR_MASK});

    always_comb begin
        ctl_d = ctl_q;
        span_d = span_q;
        result_d = result_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        rd_word = 32'h00000000;
        if (hit_ctl) begin
            rd_word = {16'h0000, ctl_q};
        end else if (hit_span) begin
            rd_word = {24'h000000, span_q};
        end
        if (conv_valid_in) begin
            result_d = conv_data_in;
        end
        // one wait state so read data leaves a flip-flop
        if (psel_in && penable_in && !pready_q) begin
            pready_d = 1'b1;
            pslverr_d = !(hit_ctl || hit_span);
            prdata_d = pwrite_in ? 32'h00000000 : rd_word;
        end
        if (app_reset_in) begin
            // app reset wins over a write in the same cycle
            ctl_d = ctl_q & `CTL_KEEP_MASK;
            span_d = span_q & `SPAN_KEEP_MASK;
        end else if (wr_commit && hit_ctl) begin
            ctl_d = ctl_merged[15:0];
        end else if (wr_commit && hit_span) begin
            span_d = span_merged[7:0];
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_q <= `CTL_RESET;
            span_q <= `SPAN_RESET;
            result_q <= 14'h0000;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            span_q <= span_d;
            result_q <= result_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // span codes pass through as written; unlisted codes are not
    // trapped, the analog range decoder treats them as it sees fit
    logic vref_off_q, vref_off_d;
    logic [3:0] span_out_q, span_out_d;
    logic [4:0] frame_len_q, frame_len_d;
    logic [27:0] frame_w;
    logic [4:0] frame_len_w;

    frame_builder u_builder (
        .result_in(result_q),
        .value_select_in(ctl_q[2:0]),
        .node_id_append_in(ctl_q[`BIT_NODE_ID_APPEND]),
        .supply_alarm_append_in(ctl_q[13:12]),
        .input_alarm_append_in(ctl_q[11:10]),
        .span_setting_append_in(ctl_q[`BIT_SPAN_SETTING_APPEND]),
        .parity_append_enable_in(ctl_q[`BIT_PARITY_APPEND_ENABLE]),
        .node_id_in(node_id_in),
        .supply_alarm_hi_in(supply_alarm_hi_in),
        .supply_alarm_lo_in(supply_alarm_lo_in),
        .input_alarm_hi_in(input_alarm_hi_in),
        .input_alarm_lo_in(input_alarm_lo_in),
        .span_select_in(span_q[3:0]),
        .frame_out(frame_w),
        .len_out(frame_len_w)
    );

    always_comb begin
        vref_off_d = span_q[`BIT_VREF_OFF];
        span_out_d = span_q[3:0];
        frame_len_d = frame_len_w;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            vref_off_q <= 1'b0;
            span_out_q <= 4'h0;
            frame_len_q <= 5'd14;
        end else begin
            vref_off_q <= vref_off_d;
            span_out_q <= span_out_d;
            frame_len_q <= frame_len_d;
        end
    end

    // pin synchronisers; stage one feeds stage two only
    logic [2:0] sclk_sync_q;
    logic [2:0] sel_sync_q;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_sync_q <= 3'h0;
            sel_sync_q <= 3'h7;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
            sel_sync_q <= {sel_sync_q[1:0], frame_sel_n_in};
        end
    end

    logic sclk_fall, sel_fall, sel_high;
    assign sclk_fall = sclk_sync_q[2] && !sclk_sync_q[1];
    assign sel_fall = sel_sync_q[2] && !sel_sync_q[1];
    assign sel_high = sel_sync_q[1];

    // frame shifter; frame is captured as it stands when select falls
    frame_ctl_pkg::shift_state_t state_q, state_d;
    logic [27:0] shift_q, shift_d;
    logic [4:0] left_q, left_d;
    logic sdo_q, sdo_d;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        left_d = left_q;
        sdo_d = sdo_q;
        case (state_q)
            frame_ctl_pkg::SHIFT_IDLE: begin
                sdo_d = 1'b0;
                if (sel_fall && !app_reset_in) begin
                    shift_d = frame_w;
                    left_d = frame_len_w;
                    sdo_d = frame_w[27];
                    state_d = frame_ctl_pkg::SHIFT_RUN;
                end
            end
            frame_ctl_pkg::SHIFT_RUN: begin
                if (sel_high || app_reset_in) begin
                    sdo_d = 1'b0;
                    state_d = frame_ctl_pkg::SHIFT_IDLE;
                end else if (sclk_fall) begin
                    shift_d = {shift_q[26:0], 1'b0};
                    left_d = left_q - 5'd1;
                    sdo_d = shift_q[26];
                    if (left_q == 5'd1) begin
                        sdo_d = 1'b0;
                        state_d = frame_ctl_pkg::SHIFT_DONE;
                    end
                end
            end
            frame_ctl_pkg::SHIFT_DONE: begin
                // extra clocks past the frame read as zero
                sdo_d = 1'b0;
                if (sel_high || app_reset_in) begin
                    state_d = frame_ctl_pkg::SHIFT_IDLE;
                end
            end
            default: begin
                sdo_d = 1'b0;
                state_d = frame_ctl_pkg::SHIFT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= frame_ctl_pkg::SHIFT_IDLE;
            shift_q <= 28'h0000000;
            left_q <= 5'd0;
            sdo_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            left_q <= left_d;
            sdo_q <= sdo_d;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign serial_out_lanes_out = sdo_q;
    assign onchip_vref_off_out = vref_off_q;
    assign span_select_out = span_out_q;
    assign frame_len_out = frame_len_q;

    a_reserved_read: assert property (@(posedge clk_in) disable iff (reset_in)
        pready_q && !pwrite_in |-> prdata_q[31:15] == 17'h00000)
        else $error("reserved read bits not zero");

    a_byte_write: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_commit && hit_ctl && pstrb_in == 4'h2 && !app_reset_in |=>
        ctl_q[15:8] == ($past(pwdata_in[15:8]) & 8'h7D) &&
        ctl_q[7:0] == $past(ctl_q[7:0]))
        else $error("byte lane write to control word wrong");

    a_app_reset: assert property (@(posedge clk_in) disable iff (reset_in)
        app_reset_in |=> ctl_q == ($past(ctl_q) & 16'h0008) &&
        span_q == ($past(span_q) & 8'h0F))
        else $error("application reset cleared wrong fields");

    a_vref_follow: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_commit && hit_span && pstrb_in[0] && !app_reset_in |=> ##1
        onchip_vref_off_out == $past(pwdata_in[6], 2))
        else $error("reference off output does not follow write");

    a_frame_len: assert property (@(posedge clk_in) disable iff (reset_in)
        ##1 frame_len_out == 5'd14 + ($past(ctl_q[14]) ? 5'd4 : 5'd0) +
        5'($past(ctl_q[13])) + 5'($past(ctl_q[12])) +
        5'($past(ctl_q[11])) + 5'($past(ctl_q[10])) +
        ($past(ctl_q[8]) ? 5'd4 : 5'd0) +
        ($past(ctl_q[3]) ? 5'd2 : 5'd0))
        else $error("frame length mismatch");

    a_pass_result: assert property (@(posedge clk_in) disable iff (reset_in)
        !ctl_q[2] |-> frame_w[27:14] == result_q)
        else $error("result not passed through");

    a_alt_pairs: assert property (@(posedge clk_in) disable iff (reset_in)
        ctl_q[2:0] == 3'h7 |-> frame_w[27:14] == 14'h0CCC)
        else $error("pair pattern wrong");

    a_result_par: assert property (@(posedge clk_in) disable iff (reset_in)
        ctl_q[3] |-> frame_w[5'd29 - frame_len_w] == ^frame_w[27:14])
        else $error("result parity wrong");

    a_first_bit: assert property (@(posedge clk_in) disable iff (reset_in)
        state_q == frame_ctl_pkg::SHIFT_IDLE && sel_fall && !app_reset_in
        |=> serial_out_lanes_out == $past(frame_w[27]) &&
        state_q == frame_ctl_pkg::SHIFT_RUN)
        else $error("first frame bit not presented");

    a_ready_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
        pready_q |=> !pready_q)
        else $error("pready held longer than one cycle");

endmodule : frame_ctl_top

// file: tb/frame_host_model.sv
// serial host: drives frame select and sclk, shifts the frame in msb first
// assumes sdo changes after each sclk fall and is sampled on sclk rise
`timescale 1ns/10ps

module frame_host_model (
    output logic sclk_out,
    output logic frame_sel_n_out,
    input wire logic sdo_in
);
    initial begin
        sclk_out = 1'b0;
        frame_sel_n_out = 1'b1;
    end

    // sclk stands still outside frames; two extra clocks probe the tail
    // start is offset from the system clock grid so phases never line up
    task automatic read_frame(input int n, output logic [31:0] f,
        output logic tail);
        f = 32'h0;
        tail = 1'b0;
        #13;
        frame_sel_n_out = 1'b0;
        #150;
        for (int i = 0; i < n + 2; i++) begin
            sclk_out = 1'b1;
            if (i < n) begin
                f = {f[30:0], sdo_in};
            end else begin
                tail = tail | sdo_in;
            end
            #100;
            sclk_out = 1'b0;
            #100;
        end
        frame_sel_n_out = 1'b1;
        #100;
    endtask : read_frame
endmodule : frame_host_model

// file: tb/tb_conversion_output_frame_control.sv
// self-checking bench for the output frame control block
// assumes apb master here and the serial host in frame_host_model
`timescale 1ns/10ps
`include "frame_ctl_regs.svh"

module tb_conversion_output_frame_control;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic app_reset_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [13:0] conv_data_in = 14'h0;
    logic conv_valid_in = 1'b0;
    logic [3:0] node_id_in = 4'h0;
    logic [3:0] alarms = 4'h0; // supply hi, supply lo, input hi, input lo
    logic sclk_in;
    logic frame_sel_n_in;
    logic serial_out_lanes_out;
    logic onchip_vref_off_out;
    logic [3:0] span_select_out;
    logic [4:0] frame_len_out;
    int num_errors = 0;
    int checked = 0;
    int len;
    logic [31:0] rd;
    logic err;
    logic [31:0] ctl;
    logic [31:0] span;
    logic [31:0] f_seen;
    logic [31:0] f_exp;
    logic tail;

    always #12.5 clk_in = ~clk_in;

    frame_ctl_top i_dut (
        .clk_in(clk_in), .reset_in(reset_in), .app_reset_in(app_reset_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .conv_data_in(conv_data_in),
        .conv_valid_in(conv_valid_in), .node_id_in(node_id_in),
        .supply_alarm_hi_in(alarms[3]), .supply_alarm_lo_in(alarms[2]),
        .input_alarm_hi_in(alarms[1]), .input_alarm_lo_in(alarms[0]),
        .sclk_in(sclk_in), .frame_sel_n_in(frame_sel_n_in),
        .serial_out_lanes_out(serial_out_lanes_out),
        .onchip_vref_off_out(onchip_vref_off_out),
        .span_select_out(span_select_out), .frame_len_out(frame_len_out)
    );

    frame_host_model i_host (
        .sclk_out(sclk_in),
        .frame_sel_n_out(frame_sel_n_in),
        .sdo_in(serial_out_lanes_out)
    );

    task automatic conclude();
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (pready_out !== 1'b1) begin
            num_errors++;
            conclude();
        end
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    // reference frame: result, id, flags, span, then the two parity bits
    function automatic void model(input logic [31:0] c,
        input logic [13:0] res, output logic [31:0] f, output int n);
        logic q[$];
        logic [13:0] v;
        logic p;
        f = 32'h0;
        p = 1'b0;
        case (c[2:0])
            3'h4: v = `PATTERN_ZEROS;
            3'h5: v = `PATTERN_ONES;
            3'h6: v = `PATTERN_ALT1;
            3'h7: v = `PATTERN_ALT2;
            default: v = res;
        endcase
        for (int i = 13; i >= 0; i--) q.push_back(v[i]);
        if (c[14]) for (int i = 3; i >= 0; i--) q.push_back(node_id_in[i]);
        if (c[12]) q.push_back(alarms[3]);
        if (c[13]) q.push_back(alarms[2]);
        if (c[10]) q.push_back(alarms[1]);
        if (c[11]) q.push_back(alarms[0]);
        if (c[8]) for (int i = 3; i >= 0; i--) q.push_back(span[i]);
        foreach (q[i]) p = p ^ q[i];
        if (c[3]) begin
            q.push_back(^v);
            q.push_back(p);
        end
        foreach (q[i]) f = {f[30:0], q[i]};
        n = q.size();
    endfunction : model

    initial begin
        #1000000;
        num_errors++;
        conclude();
    end

    initial begin
        rd = $urandom(32'h8C9B5FD5);
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        apb(1'b0, 8'h10, 32'h0, 4'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0, 4'h0, rd, err);
        chk(rd, 32'h0);
        chk(frame_len_out, 32'hE);
        apb(1'b1, 8'h20, 32'hFFFFFFFF, 4'hF, rd, err);
        chk(err, 32'h1);
        apb(1'b0, 8'h20, 32'h0, 4'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        // lanes written one at a time, lowest lane first
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, 8'h10, 32'hFFFFFFFF, 4'(4'h1 << b), rd, err);
            apb(1'b0, 8'h10, 32'h0, 4'h0, rd, err);
            chk(rd, (32'hFFFFFFFF >> (8 * (3 - b))) & 32'h7D0F);
        end
        for (int k = 0; k < 16; k++) begin
            ctl = $urandom();
            if (k < 8) ctl[2:0] = 3'(k);
            span = $urandom();
            apb(1'b1, 8'h10, ctl, 4'hF, rd, err);
            apb(1'b1, 8'h14, span, 4'hF, rd, err);
            apb(1'b0, 8'h10, 32'h0, 4'h0, rd, err);
            chk(rd, ctl & 32'h7D0F);
            chk(err, 32'h0);
            apb(1'b0, 8'h14, 32'h0, 4'h0, rd, err);
            chk(rd, span & 32'h4F);
            chk(span_select_out, span[3:0]);
            chk(onchip_vref_off_out, span[6]);
            node_id_in <= 4'($urandom());
            alarms <= 4'($urandom());
            conv_data_in <= 14'($urandom());
            conv_valid_in <= 1'b1;
            @(posedge clk_in);
            conv_valid_in <= 1'b0;
            @(posedge clk_in);
            model(ctl, conv_data_in, f_exp, len);
            chk(frame_len_out, len);
            i_host.read_frame(len, f_seen, tail);
            chk(f_seen, f_exp);
            chk(tail, 32'h0);
        end
        apb(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF, rd, err);
        apb(1'b1, 8'h14, 32'hFFFFFFFF, 4'hF, rd, err);
        @(posedge clk_in);
        app_reset_in <= 1'b1;
        @(posedge clk_in);
        app_reset_in <= 1'b0;
        apb(1'b0, 8'h10, 32'h0, 4'h0, rd, err);
        chk(rd, 32'h8);
        apb(1'b0, 8'h14, 32'h0, 4'h0, rd, err);
        chk(rd, 32'hF);
        // second power-on reset in mid-run clears the kept fields too
        @(posedge clk_in);
        reset_in <= 1'b1;
        @(posedge clk_in);
        reset_in <= 1'b0;
        apb(1'b0, 8'h10, 32'h0, 4'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0, 4'h0, rd, err);
        chk(rd, 32'h0);
        chk(frame_len_out, 32'hE);
        conclude();
    end
endmodule : tb_conversion_output_frame_control
